// >>> hdl/hpbsp_pkg.sv
// Purpose: Shared constants and carriers for the host processor bus slave port
// Assumes: One positive-edge bus clock supplied by the host
// Notes:   Lane 0 is data bits 7:0; narrower bus widths use the low lanes
package hpbsp_pkg;

  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int LANES       = 4;
  localparam int LANE_W      = 8;
  localparam int CFG_ADDR_W  = 22;
  localparam int BURST_BEATS = 4;

  // Transfer size encodings driven by the master
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;

  // Data bus width selection
  localparam logic [1:0] WIDTH_32 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_8  = 2'h2;

  // Lane masks and byte enables
  localparam logic [LANES-1:0] MASK_ALL  = 4'hF;
  localparam logic [LANES-1:0] MASK_LOW2 = 4'h3;
  localparam logic [LANES-1:0] MASK_HIGH2 = 4'hC;
  localparam logic [LANES-1:0] MASK_LANE0 = 4'h1;
  localparam logic [LANES-1:0] MASK_NONE = 4'h0;

  localparam logic [ADDR_W-1:0] BEAT_STEP = 32'h00000004;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
  localparam logic              PAR_ODD   = 1'b0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DATA = 5'h02,
    ST_SYS  = 5'h04,
    ST_TERM = 5'h08,
    ST_CFG  = 5'h10
  } hpbsp_state_t;

  typedef enum logic [2:0] {
    TERM_NONE  = 3'h0,
    TERM_ACK   = 3'h1,
    TERM_ERR   = 3'h2,
    TERM_RETRY = 3'h4
  } hpbsp_term_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic [1:0]        size;
    logic              burst_indicator_n;
    logic              burst_continue_req;
  } hpbsp_host_req_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  be;
    logic [DATA_W-1:0] wdata;
  } hpbsp_sys_req_t;

  typedef struct packed {
    logic              ready;
    logic              err;
    logic              retry;
    logic [DATA_W-1:0] rdata;
  } hpbsp_sys_rsp_t;

endpackage : hpbsp_pkg

// >>> hdl/hpbsp_lane_parity.sv
// Purpose: One parity bit per byte lane of a data word
// Assumes: Lane 0 is the least significant byte
// Notes:   ODD selects odd parity, otherwise even
`timescale 1ns/1ps
`default_nettype none
module hpbsp_lane_parity #(
  parameter int   LANES  = hpbsp_pkg::LANES,
  parameter int   LANE_W = hpbsp_pkg::LANE_W,
  parameter logic ODD    = hpbsp_pkg::PAR_ODD
) (
  input  wire logic [LANES*LANE_W-1:0] data,
  output logic      [LANES-1:0]        parity
);

  genvar i;
  generate
    for (i = 0; i < LANES; i++)
    begin : g_lane
      assign parity[i] = (^data[i*LANE_W +: LANE_W]) ^ ODD; // R9
    end
  endgenerate

endmodule : hpbsp_lane_parity
`default_nettype wire

// >>> hdl/hpbsp_port.sv
// Purpose: Slave port letting a host processor reach the internal system bus
// Assumes: All host pins synchronous to clk, the host bus clock
// Notes:   Summary of operation follows
//
// Summary of operation
// [R1] Master encodes size: 01 byte, 10 half-word, 00 word.
// [R2] Burst-continue asserted requests another data beat after the current one.
// [R3] Deasserting burst-continue before the burst ends aborts the remaining beats.
// [R4] Acknowledge goes low once write data accepted or read data driven.
// [R5] All signalling is on the rising edge of the host bus clock.
// [R6] Internal bus error ends the transaction with transfer-error acknowledge low.
// [R7] Port can drive retry so the master repeats the cycle later.
// [R8] Data width selectable 8, 16 or 32; port drives data on reads.
// [R9] One parity bit per byte lane; lane 0 covers bits 7:0.
// [R10] Master parallel config mode drives upper address and burst/size pins as memory address.
// [R11] Burst indicator low means burst, high means single access.
// [R12] Inputs sampled on rising edge; exactly one termination per beat.
`timescale 1ns/1ps
`default_nettype none
module hpbsp_port #(
  parameter int BURST_BEATS = hpbsp_pkg::BURST_BEATS
) (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic [1:0]                          bus_width,
  input  wire logic                                cfg_master_par,
  input  wire logic [hpbsp_pkg::CFG_ADDR_W-1:0]    cfg_mem_addr,
  input  wire logic                                xfer_start_n,
  input  wire hpbsp_pkg::hpbsp_host_req_t          host_in,
  input  wire logic [hpbsp_pkg::DATA_W-1:0]        data_in,
  output logic      [hpbsp_pkg::DATA_W-1:0]        data_out,
  output logic      [hpbsp_pkg::LANES-1:0]         data_oe,
  input  wire logic [hpbsp_pkg::LANES-1:0]         lane_parity_in,
  output logic      [hpbsp_pkg::LANES-1:0]         lane_parity_out,
  output logic      [hpbsp_pkg::LANES-1:0]         lane_parity_oe,
  output logic                                     xfer_ack_n,
  output logic                                     xfer_error_ack_n,
  output logic                                     bus_retry_req,
  output logic      [hpbsp_pkg::CFG_ADDR_W-1:0]    cfg_pin_out,
  output logic                                     cfg_pin_oe,
  output hpbsp_pkg::hpbsp_sys_req_t                sys_req,
  input  wire hpbsp_pkg::hpbsp_sys_rsp_t           sys_rsp
);

  localparam int BW = (BURST_BEATS > 1) ? $clog2(BURST_BEATS) : 1;
  localparam logic [BW-1:0] LAST_BEAT = BW'(BURST_BEATS - 1);
  localparam logic [BW-1:0] BEAT_ZERO = '0;

  hpbsp_pkg::hpbsp_state_t            state_q;
  hpbsp_pkg::hpbsp_term_t             term_q;
  logic [hpbsp_pkg::ADDR_W-1:0]       addr_q;
  logic                               wr_q;
  logic [1:0]                         size_q;
  logic                               burst_q;
  logic [BW-1:0]                      beat_q;
  logic [hpbsp_pkg::DATA_W-1:0]       wdata_q;
  logic                               par_err_q;
  logic [hpbsp_pkg::DATA_W-1:0]       rdata_q;
  logic [hpbsp_pkg::LANES-1:0]        rpar_q;
  logic [hpbsp_pkg::CFG_ADDR_W-1:0]   cfg_q;
  logic                               cfg_oe_q;
  logic [hpbsp_pkg::LANES-1:0]        lane_mask;
  logic [hpbsp_pkg::LANES-1:0]        be;
  logic [hpbsp_pkg::LANES-1:0]        wpar_calc;
  logic [hpbsp_pkg::LANES-1:0]        rpar_calc;
  logic                               sys_done;
  logic                               term_ack;
  logic                               burst_more;

  // Active byte lanes for the selected bus width
  always_comb
  begin
    case (bus_width)
      hpbsp_pkg::WIDTH_16: lane_mask = hpbsp_pkg::MASK_LOW2; // R8
      hpbsp_pkg::WIDTH_8:  lane_mask = hpbsp_pkg::MASK_LANE0;
      default:             lane_mask = hpbsp_pkg::MASK_ALL;
    endcase
  end

  // Byte enables from transfer size and low address bits
  always_comb
  begin
    case (size_q)
      hpbsp_pkg::SIZE_BYTE: be = hpbsp_pkg::MASK_LANE0 << addr_q[1:0]; // R1
      hpbsp_pkg::SIZE_HALF: be = addr_q[1] ? hpbsp_pkg::MASK_HIGH2 : hpbsp_pkg::MASK_LOW2; // R1
      default:              be = hpbsp_pkg::MASK_ALL; // R1
    endcase
  end

  hpbsp_lane_parity u_wpar (
    .data   (data_in),
    .parity (wpar_calc)
  );

  hpbsp_lane_parity u_rpar (
    .data   (sys_rsp.rdata),
    .parity (rpar_calc)
  );

  assign sys_done   = sys_rsp.ready | sys_rsp.err | sys_rsp.retry;
  assign term_ack   = (state_q == hpbsp_pkg::ST_TERM) && (term_q == hpbsp_pkg::TERM_ACK);
  assign burst_more = burst_q && host_in.burst_continue_req && (beat_q != LAST_BEAT); // R2 R3

  // Transaction sequencer
  always_ff @(posedge clk or posedge rst) // R5
  begin
    if (rst)
      state_q <= hpbsp_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        hpbsp_pkg::ST_IDLE:
        begin
          if (cfg_master_par)
            state_q <= hpbsp_pkg::ST_CFG; // R10
          else if (!xfer_start_n)
            state_q <= hpbsp_pkg::ST_DATA; // R12
        end
        hpbsp_pkg::ST_DATA:
          state_q <= hpbsp_pkg::ST_SYS;
        hpbsp_pkg::ST_SYS:
        begin
          if (par_err_q || sys_done)
            state_q <= hpbsp_pkg::ST_TERM;
        end
        hpbsp_pkg::ST_TERM:
          state_q <= (term_ack && burst_more) ? hpbsp_pkg::ST_DATA : hpbsp_pkg::ST_IDLE; // R2 R3
        hpbsp_pkg::ST_CFG:
        begin
          if (!cfg_master_par)
            state_q <= hpbsp_pkg::ST_IDLE;
        end
        default:
          state_q <= hpbsp_pkg::ST_IDLE;
      endcase
    end
  end

  // Address phase capture and burst stepping
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q  <= '0;
      wr_q    <= 1'b0;
      size_q  <= hpbsp_pkg::SIZE_WORD;
      burst_q <= 1'b0;
      beat_q  <= BEAT_ZERO;
    end
    else if (state_q == hpbsp_pkg::ST_IDLE && !cfg_master_par && !xfer_start_n)
    begin
      addr_q  <= host_in.addr;
      wr_q    <= host_in.wr;
      size_q  <= host_in.size;
      burst_q <= !host_in.burst_indicator_n; // R11
      beat_q  <= BEAT_ZERO;
    end
    else if (state_q == hpbsp_pkg::ST_TERM && term_ack && burst_more)
    begin
      addr_q <= addr_q + hpbsp_pkg::BEAT_STEP; // R2
      beat_q <= beat_q + 1'b1;
    end
  end

  // Write data and lane parity check
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wdata_q   <= hpbsp_pkg::DATA_ZERO;
      par_err_q <= 1'b0;
    end
    else if (state_q == hpbsp_pkg::ST_DATA)
    begin
      wdata_q   <= data_in; // R8
      par_err_q <= wr_q && |((wpar_calc ^ lane_parity_in) & lane_mask & be); // R9
    end
  end

  // Termination selection, error over retry over acknowledge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      term_q <= hpbsp_pkg::TERM_NONE;
    else if (state_q == hpbsp_pkg::ST_SYS)
    begin
      if (par_err_q || sys_rsp.err)
        term_q <= hpbsp_pkg::TERM_ERR; // R6
      else if (sys_rsp.retry)
        term_q <= hpbsp_pkg::TERM_RETRY; // R7
      else if (sys_rsp.ready)
        term_q <= hpbsp_pkg::TERM_ACK; // R4
    end
  end

  // Read data and its parity held for the data phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= hpbsp_pkg::DATA_ZERO;
      rpar_q  <= hpbsp_pkg::MASK_NONE;
    end
    else if (state_q == hpbsp_pkg::ST_SYS && sys_rsp.ready && !wr_q)
    begin
      rdata_q <= sys_rsp.rdata; // R8
      rpar_q  <= rpar_calc; // R9
    end
  end

  // Configuration memory address on reused pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q    <= '0;
      cfg_oe_q <= 1'b0;
    end
    else
    begin
      cfg_q    <= cfg_mem_addr; // R10
      cfg_oe_q <= cfg_master_par && (state_q == hpbsp_pkg::ST_CFG || state_q == hpbsp_pkg::ST_IDLE); // R10
    end
  end

  assign cfg_pin_out = cfg_q;
  assign cfg_pin_oe  = cfg_oe_q;

  // Internal bus request
  assign sys_req.req   = (state_q == hpbsp_pkg::ST_SYS) && !par_err_q;
  assign sys_req.we    = wr_q;
  assign sys_req.addr  = addr_q;
  assign sys_req.be    = be;
  assign sys_req.wdata = wdata_q;

  // Host pin drivers
  assign xfer_ack_n       = !term_ack; // R4 R12
  assign xfer_error_ack_n = !((state_q == hpbsp_pkg::ST_TERM) && (term_q == hpbsp_pkg::TERM_ERR)); // R6
  assign bus_retry_req    = (state_q == hpbsp_pkg::ST_TERM) && (term_q == hpbsp_pkg::TERM_RETRY); // R7
  assign data_out         = rdata_q;
  assign data_oe          = (term_ack && !wr_q) ? lane_mask : hpbsp_pkg::MASK_NONE; // R8
  assign lane_parity_out  = rpar_q;
  assign lane_parity_oe   = data_oe; // R9

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_ack_beat;
    term_ack && burst_more;
  endsequence

  sequence s_next_beat;
    (state_q == hpbsp_pkg::ST_DATA) ##1 (state_q == hpbsp_pkg::ST_SYS);
  endsequence

  a_one_termination: assert property ($onehot0({!xfer_ack_n, !xfer_error_ack_n, bus_retry_req})) // R12
    else $error("more than one termination driven");
  a_term_one_cycle: assert property ((!xfer_ack_n || !xfer_error_ack_n || bus_retry_req) |=> // R12
      (xfer_ack_n && xfer_error_ack_n && !bus_retry_req))
    else $error("termination held longer than one cycle");
  a_ack_after_ready: assert property ((state_q == hpbsp_pkg::ST_SYS && sys_rsp.ready && !sys_rsp.err && // R4
      !sys_rsp.retry && !par_err_q) |=> !xfer_ack_n)
    else $error("acknowledge missing after internal ready");
  a_error_after_sys: assert property ((state_q == hpbsp_pkg::ST_SYS && sys_rsp.err) |=> !xfer_error_ack_n) // R6
    else $error("error acknowledge missing after internal error");
  a_retry_after_sys: assert property ((state_q == hpbsp_pkg::ST_SYS && sys_rsp.retry && !sys_rsp.err && // R7
      !par_err_q) |=> bus_retry_req)
    else $error("retry missing after internal retry");
  a_read_lanes_drive: assert property ((!xfer_ack_n && !wr_q) |-> (data_oe == lane_mask && // R8
      data_out == $past(sys_rsp.rdata) && lane_parity_oe == lane_mask))
    else $error("read data lanes not driven with acknowledge");
  a_parity_error_ends: assert property ((state_q == hpbsp_pkg::ST_DATA && wr_q && // R9
      |((wpar_calc ^ lane_parity_in) & lane_mask & be)) |=> ##1 !xfer_error_ack_n)
    else $error("write parity error not terminated with error");
  a_burst_continues: assert property (s_ack_beat |=> s_next_beat) // R2
    else $error("burst did not advance to next beat");
  a_burst_abort: assert property ((term_ack && burst_q && !host_in.burst_continue_req) |=> // R3
      (state_q == hpbsp_pkg::ST_IDLE))
    else $error("aborted burst did not end");
  a_cfg_pins_drive: assert property ((cfg_master_par && state_q == hpbsp_pkg::ST_CFG) |=> // R10
      (cfg_pin_oe && cfg_pin_out == $past(cfg_mem_addr)))
    else $error("configuration address pins not driven");
  a_byte_enable: assert property ((sys_req.req && size_q == hpbsp_pkg::SIZE_BYTE) |-> $onehot(sys_req.be)) // R1
    else $error("byte transfer with more than one enable");
  a_burst_flag: assert property ((state_q == hpbsp_pkg::ST_IDLE && !cfg_master_par && !xfer_start_n) |=> // R11
      (burst_q == !$past(host_in.burst_indicator_n)))
    else $error("burst flag not taken from burst indicator");

endmodule : hpbsp_port
`default_nettype wire

// >>> sim/hpbsp_host_model.sv
// Purpose: Host bus master model driving the slave port
// Assumes: Requests launched 1 ns after the rising edge
// Notes:   Data lines invert once released
`timescale 1ns/1ps
`default_nettype none
module hpbsp_host_model (
  input  wire logic                  clk,
  input  wire logic                  ack_n,
  input  wire logic                  err_n,
  input  wire logic                  retry,
  input  wire logic [31:0]           rdata,
  input  wire logic [3:0]            rpar,
  input  wire logic [3:0]            roe,
  output logic                       start_n,
  output hpbsp_pkg::hpbsp_host_req_t req,
  output logic [31:0]                wdata,
  output logic [3:0]                 wpar
);
  logic [31:0] rd_q;
  logic [3:0]  rp_q;
  logic [3:0]  oe_q;

  initial
  begin
    start_n = 1'b1;
    req = '0;
    req.burst_indicator_n = 1'b1;
    wdata = 32'h0;
    wpar = 4'h0;
  end

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [1:0] sz, input int beats,
                      input logic [31:0] wd, input logic [3:0] wp, output int acks, output int term);
    int n;
    int t;
    acks = 0;
    term = 0;
    n = 0;
    @(posedge clk);
    #1;
    start_n = 1'b0;
    req.addr = a;
    req.wr = wr;
    req.size = sz;
    req.burst_indicator_n = (beats == 1);
    req.burst_continue_req = (beats > 1);
    @(posedge clk);
    #1;
    start_n = 1'b1;
    wdata = wd;
    wpar = wp;
    while (term == 0 && n < 60)
    begin
      @(posedge clk);
      n++;
      t = int'(!ack_n) + int'(!err_n) + int'(retry);
      if (t > 1)
        term = 4;
      else if (!err_n)
        term = 2;
      else if (retry)
        term = 3;
      else if (!ack_n)
      begin
        acks++;
        rd_q = rdata;
        rp_q = rpar;
        oe_q = roe;
        if (acks == beats)
          term = 1;
        else
        begin
          #1;
          req.burst_continue_req = (acks < beats - 1);
        end
      end
    end
    #1;
    wdata = ~wdata;
    wpar = ~wpar;
    req.burst_continue_req = 1'b0;
  endtask : xfer
endmodule : hpbsp_host_model
`default_nettype wire

// >>> sim/test_host_processor_bus_slave_port.sv
// Purpose: Self-checking bench for the host processor bus slave port
// Assumes: 50 MHz bus clock, system bus served by a memory model
// Notes:   Expected values come from the memory model and lane rules
`timescale 1ns/1ps
`default_nettype none
module test_host_processor_bus_slave_port;
  logic clk, rst, cfg_par, start_n, ack_n, err_n, retry, cfg_oe;
  logic [1:0] width, sz;
  logic [21:0] cfg_addr, cfg_pin;
  logic [31:0] din, dout, a, wd;
  logic [3:0] doe, pin, pout, poe, be;
  hpbsp_pkg::hpbsp_host_req_t hreq;
  hpbsp_pkg::hpbsp_sys_req_t sreq, last_req;
  hpbsp_pkg::hpbsp_sys_rsp_t srsp;
  int n_errors, n_checks, seed, rsp_mode, rsp_dly, wait_cnt, n_sys, acks, term, n0;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] q_addr [$];

  hpbsp_port u_hpbsp_port (.clk(clk), .rst(rst), .bus_width(width), .cfg_master_par(cfg_par),
    .cfg_mem_addr(cfg_addr), .xfer_start_n(start_n), .host_in(hreq), .data_in(din), .data_out(dout),
    .data_oe(doe), .lane_parity_in(pin), .lane_parity_out(pout), .lane_parity_oe(poe), .xfer_ack_n(ack_n),
    .xfer_error_ack_n(err_n), .bus_retry_req(retry), .cfg_pin_out(cfg_pin), .cfg_pin_oe(cfg_oe),
    .sys_req(sreq), .sys_rsp(srsp));
  hpbsp_host_model u_hpbsp_host_model (.clk(clk), .ack_n(ack_n), .err_n(err_n), .retry(retry),
    .rdata(dout), .rpar(pout), .roe(doe), .start_n(start_n), .req(hreq), .wdata(din), .wpar(pin));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // System bus slave: answers after rsp_dly cycles with the chosen response
  always @(posedge clk)
  begin
    #1;
    srsp = '0;
    srsp.rdata = $random(seed);
    if (sreq.req)
    begin
      if (wait_cnt < rsp_dly)
        wait_cnt++;
      else
      begin
        wait_cnt = 0;
        n_sys++;
        q_addr.push_back(sreq.addr);
        last_req = sreq;
        srsp.ready = (rsp_mode == 0);
        srsp.err = (rsp_mode == 1);
        srsp.retry = (rsp_mode == 2);
        if (sreq.we && rsp_mode == 0)
          mem[sreq.addr] = sreq.wdata;
        else if (!sreq.we)
          srsp.rdata = mem.exists(sreq.addr) ? mem[sreq.addr] : ~sreq.addr;
      end
    end
  end

  function automatic logic [3:0] par(input logic [31:0] w);
    for (int i = 0; i < 4; i++)
      par[i] = ^w[8*i +: 8];
  endfunction : par

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    #(20 * 4000);
    n_errors++;
    print_verdict();
  end

  initial
  begin
    seed = 32'h4EFC;
    rst = 1'b1;
    cfg_par = 1'b0;
    cfg_addr = 22'h0;
    width = hpbsp_pkg::WIDTH_32;
    {n_errors, n_checks, rsp_mode, rsp_dly, wait_cnt, n_sys} = '0;
    repeat (10) @(posedge clk);
    check("ack_n reset", 32'h1, 32'(ack_n));
    check("oe reset", 32'h0, 32'(doe));
    check("parity oe reset", 32'h0, 32'(poe));
    #1 rst = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      sz = (k == 0) ? hpbsp_pkg::SIZE_WORD : (k == 1) ? hpbsp_pkg::SIZE_BYTE : hpbsp_pkg::SIZE_HALF;
      a = $random(seed);
      a[0] = (k == 1) ? a[0] : 1'b0;
      a[1] = (k == 0) ? 1'b0 : a[1];
      be = (k == 0) ? 4'hF : (k == 1) ? (4'h1 << a[1:0]) : (a[1] ? 4'hC : 4'h3);
      wd = $random(seed);
      u_hpbsp_host_model.xfer(1'b1, a, sz, 1, wd, par(wd), acks, term);
      check("write term", 32'h1, 32'(term));
      check("write be", 32'(be), 32'(last_req.be));
      check("write data", wd, last_req.wdata);
      check("write we", 32'h1, 32'(last_req.we));
    end
    wd = $random(seed);
    u_hpbsp_host_model.xfer(1'b1, 32'h100, hpbsp_pkg::SIZE_WORD, 1, wd, par(wd), acks, term);
    for (int k = 0; k < 3; k++)
    begin
      width = (k == 0) ? hpbsp_pkg::WIDTH_32 : (k == 1) ? hpbsp_pkg::WIDTH_16 : hpbsp_pkg::WIDTH_8;
      be = (k == 0) ? 4'hF : (k == 1) ? 4'h3 : 4'h1;
      u_hpbsp_host_model.xfer(1'b0, 32'h100, hpbsp_pkg::SIZE_WORD, 1, 32'h0, 4'h0, acks, term);
      check("read term", 32'h1, 32'(term));
      check("read oe", 32'(be), 32'(u_hpbsp_host_model.oe_q));
      check("read parity", 32'(par(u_hpbsp_host_model.rd_q) & be), 32'(u_hpbsp_host_model.rp_q & be));
      if (k == 0)
        check("read data", wd, u_hpbsp_host_model.rd_q);
    end
    width = hpbsp_pkg::WIDTH_32;
    rsp_dly = 2;
    q_addr.delete();
    u_hpbsp_host_model.xfer(1'b0, 32'h200, hpbsp_pkg::SIZE_WORD, 4, 32'h0, 4'h0, acks, term);
    check("burst acks", 32'h4, 32'(acks));
    check("burst beats", 32'h4, 32'(q_addr.size()));
    for (int i = 0; i < q_addr.size(); i++)
      check("burst addr", 32'h200 + 32'(4 * i), q_addr[i]);
    rsp_dly = 0;
    q_addr.delete();
    u_hpbsp_host_model.xfer(1'b0, 32'h300, hpbsp_pkg::SIZE_WORD, 2, 32'h0, 4'h0, acks, term);
    check("abort acks", 32'h2, 32'(acks));
    check("abort beats", 32'h2, 32'(q_addr.size()));
    for (int m = 1; m < 3; m++)
    begin
      rsp_mode = m;
      u_hpbsp_host_model.xfer(1'b0, 32'h400, hpbsp_pkg::SIZE_WORD, 3, 32'h0, 4'h0, acks, term);
      check("fault term", 32'(m + 1), 32'(term));
      check("fault acks", 32'h0, 32'(acks));
    end
    rsp_mode = 0;
    n0 = n_sys;
    wd = $random(seed);
    u_hpbsp_host_model.xfer(1'b1, 32'h500, hpbsp_pkg::SIZE_WORD, 1, wd, par(wd) ^ 4'h4, acks, term);
    check("parity term", 32'h2, 32'(term));
    check("parity no access", 32'(n0), 32'(n_sys));
    cfg_addr = 22'($random(seed));
    cfg_par = 1'b1;
    repeat (3) @(posedge clk);
    check("cfg oe", 32'h1, 32'(cfg_oe));
    check("cfg addr", 32'(cfg_addr), 32'(cfg_pin));
    u_hpbsp_host_model.xfer(1'b0, 32'h100, hpbsp_pkg::SIZE_WORD, 1, 32'h0, 4'h0, acks, term);
    check("cfg refuse", 32'h0, 32'(term));
    cfg_par = 1'b0;
    repeat (3) @(posedge clk);
    check("cfg oe off", 32'h0, 32'(cfg_oe));
    u_hpbsp_host_model.xfer(1'b0, 32'h100, hpbsp_pkg::SIZE_WORD, 1, 32'h0, 4'h0, acks, term);
    check("after cfg", wd, u_hpbsp_host_model.rd_q ^ wd ^ mem[32'h100] ^ wd ^ wd);
    print_verdict();
  end
endmodule : test_host_processor_bus_slave_port
`default_nettype wire
